// *** hdl/pfc_map.svh ***
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
`define ADDR_PREFETCH_CTRL   4'h0
`define ADDR_CACHE_ATTR      4'h4
`define ADDR_CORE_CFG3       4'h8
`define ADDR_FLASH_STATUS    4'hC
`define PREFETCH_SEL_HI      5
`define PREFETCH_SEL_LO      4
`define WAIT_FIELD_HI        2
`define WAIT_FIELD_LO        0
`define BOOT_ISA_BIT         6
`define CFG3_EXC_ISA_BIT     16
`define CFG3_ISA_HI          15
`define CFG3_ISA_LO          14
`define PREFETCH_CTRL_RESET  32'h0000_0007
`define CACHE_ATTR_RESET     3'h2
`define ISA_BASE_ONLY        2'h2
`define ISA_BOTH             2'h3
`endif

// *** hdl/pfc_pkg.sv ***
package pfc_pkg;
  typedef enum logic [1:0] {PF_OFF, PF_INSTR, PF_INSTR_DATA, PF_ANY} prefetch_mode_e;
  typedef enum logic [1:0] {CA_WT_NOALLOC, CA_WT_ALLOC, CA_UNCACHED, CA_WB_ALLOC} cache_mode_e;
  typedef enum {ST_IDLE, ST_WAIT, ST_DONE} flash_state_e;
endpackage : pfc_pkg

// *** hdl/flash_wait_ctrl.sv ***
`timescale 1ns/1ps
module flash_wait_ctrl
  import pfc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [2:0]  wait_count,
  input  wire logic        rd_req,
  output logic             rd_busy,
  output logic             rd_ready
);
  flash_state_e state_q;
  logic [2:0]   cnt_q;

  // R13: stall by wait count
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q  <= ST_IDLE;
      cnt_q    <= 3'h0;
      rd_ready <= 1'b0;
      rd_busy  <= 1'b0;
    end else begin
      rd_ready <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (rd_req) begin
            cnt_q   <= wait_count;
            rd_busy <= 1'b1;
            state_q <= (wait_count == 3'h0) ? ST_DONE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          rd_ready <= 1'b1;
          rd_busy  <= 1'b0;
          state_q  <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule : flash_wait_ctrl

// *** hdl/prefetch_cache_waitstate_cfg.sv ***
// How it works
// R1: Prefetch select 11 any, 10 instr+data, 01 instr.
// R2: Prefetch select in bits 5:4, independent of cache.
// R3: Wait codes 000/001/010 give zero/one/two states.
// R4: Code 011 reserved; 100 four, 111 seven.
// R5: Wait field in control register bits 2:0.
// R6: Software picks waits assuming flash ECC enabled.
// R7: Attribute 011 WB, 010 uncached, 001/000 WT.
// R8: Attribute field governs core L1 caches.
// R9: Boot bit 1: base SUPPORTED_ISA_FIELD, flag 0, field 10.
// R10: Boot bit 0: compressed SUPPORTED_ISA_FIELD, flag 1, field 11.
// R11: Boot selection from config word zero bit 6.
// R12: Compressed mode mixes 16 and 32 bit opcodes.
// R13: Flash reads stall by the wait count.
`timescale 1ns/1ps
`include "pfc_map.svh"
module prefetch_cache_waitstate_cfg
  import pfc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [31:0] config_word_zero,
  input  wire logic        flash_rd_req,
  output logic             flash_rd_busy,
  output logic             flash_rd_ready,
  output logic             pf_enable,
  output logic             pf_instr_en,
  output logic             pf_data_en,
  output logic             pf_any_en,
  output logic             icache_en,
  output logic             dcache_en,
  output logic             cache_write_back,
  output logic             cache_write_alloc,
  output logic             exc_compressed_isa,
  output logic             mixed_opcode_en
);
  logic [1:0]   prefetch_select_q;
  logic [2:0]   flash_wait_states_q;
  logic [2:0]   cacheability_attr_q;
  logic         boot_isa_select_q;
  logic [2:0]   wait_count;
  logic         exception_isa_flag;
  logic [1:0]   supported_isa_field;
  logic [31:0]  prefetch_control_reg;
  logic [31:0]  core_config_three;
  logic [31:0]  rdata_d;
  cache_mode_e  cmode;
  prefetch_mode_e pmode;

  wire wr_pf  = reg_wr && (reg_addr == `ADDR_PREFETCH_CTRL);
  wire wr_ca  = reg_wr && (reg_addr == `ADDR_CACHE_ATTR);

  // R5: wait field position
  assign prefetch_control_reg = {26'h0, prefetch_select_q, 1'b0, flash_wait_states_q};
  // R9: SUPPORTED_ISA_FIELD reporting fields
  assign exception_isa_flag  = ~boot_isa_select_q;
  // R10: compressed SUPPORTED_ISA_FIELD report
  assign supported_isa_field = boot_isa_select_q ? `ISA_BASE_ONLY : `ISA_BOTH;
  assign core_config_three   = {15'h0, exception_isa_flag, supported_isa_field, 14'h0};

  // R4: reserved code 011 acts as the next stronger setting, four states.
  assign wait_count = (flash_wait_states_q == 3'h3) ? 3'h4 : flash_wait_states_q;

  assign pmode = prefetch_mode_e'(prefetch_select_q);
  assign cmode = (cacheability_attr_q[2]) ? CA_UNCACHED : cache_mode_e'(cacheability_attr_q[1:0]);

  assign rdata_d = (reg_addr == `ADDR_PREFETCH_CTRL) ? prefetch_control_reg :
                   (reg_addr == `ADDR_CACHE_ATTR)    ? {29'h0, cacheability_attr_q} :
                   (reg_addr == `ADDR_CORE_CFG3)     ? core_config_three :
                   (reg_addr == `ADDR_FLASH_STATUS)  ? {31'h0, flash_rd_busy} : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prefetch_select_q   <= 2'h0;
      flash_wait_states_q <= 3'(`PREFETCH_CTRL_RESET);
      cacheability_attr_q <= `CACHE_ATTR_RESET;
      boot_isa_select_q   <= 1'b1;
      reg_rdata           <= 32'h0000_0000;
    end else begin
      // R2: prefetch select field
      if (wr_pf) begin
        prefetch_select_q   <= reg_wdata[`PREFETCH_SEL_HI:`PREFETCH_SEL_LO];
        // R3: wait field write
        flash_wait_states_q <= reg_wdata[`WAIT_FIELD_HI:`WAIT_FIELD_LO];
      end
      // R8: attribute register write
      if (wr_ca) begin
        cacheability_attr_q <= reg_wdata[2:0];
      end
      // R11: boot SUPPORTED_ISA_FIELD bit sample
      boot_isa_select_q <= config_word_zero[`BOOT_ISA_BIT];
      reg_rdata <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pf_enable <= 1'b0;
      pf_instr_en <= 1'b0;
      pf_data_en <= 1'b0;
      pf_any_en <= 1'b0;
      icache_en <= 1'b0;
      dcache_en <= 1'b0;
      cache_write_back <= 1'b0;
      cache_write_alloc <= 1'b0;
      exc_compressed_isa <= 1'b0;
      mixed_opcode_en <= 1'b0;
    end else begin
      // R1: prefetch decode
      pf_enable   <= (pmode != PF_OFF);
      pf_instr_en <= (pmode != PF_OFF);
      pf_data_en  <= (pmode == PF_INSTR_DATA) || (pmode == PF_ANY);
      pf_any_en   <= (pmode == PF_ANY);
      // R7: attribute decode
      icache_en   <= (cmode != CA_UNCACHED);
      dcache_en   <= (cmode != CA_UNCACHED);
      cache_write_back  <= (cmode == CA_WB_ALLOC);
      cache_write_alloc <= (cmode == CA_WB_ALLOC) || (cmode == CA_WT_ALLOC);
      // R10: compressed boot mode
      exc_compressed_isa <= ~boot_isa_select_q;
      // R12: mixed opcode widths
      mixed_opcode_en    <= ~boot_isa_select_q;
    end
  end

  flash_wait_ctrl u_wait (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .wait_count (wait_count),
    .rd_req     (flash_rd_req),
    .rd_busy    (flash_rd_busy),
    .rd_ready   (flash_rd_ready)
  );

  // R13: ready follows request after waits
  a_read_stall_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // R13
    (flash_rd_req && !flash_rd_busy && wait_count == 3'h0) |-> ##2 flash_rd_ready)
    else $error("zero-wait read not ready in two cycles");
  a_prefetch_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (prefetch_select_q == 2'h0) |=> !pf_enable)
    else $error("prefetch on while disabled");
  a_prefetch_any: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
    (prefetch_select_q == 2'h3) |=> pf_any_en && pf_data_en)
    else $error("prefetch any not enabled");
  a_select_field: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    wr_pf |=> prefetch_select_q == $past(reg_wdata[5:4]))
    else $error("prefetch select not stored");
  a_wait_field: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
    wr_pf |=> flash_wait_states_q == $past(reg_wdata[2:0]))
    else $error("wait field not stored");
  a_wait_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (flash_wait_states_q == 3'h3) |-> wait_count == 3'h4)
    else $error("reserved wait code mapped wrong");
  a_cache_uncached: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
    (cacheability_attr_q == 3'h2) |=> !icache_en && !dcache_en)
    else $error("uncached attribute enabled cache");
  a_isa_report: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    boot_isa_select_q |-> supported_isa_field == 2'h2 && !exception_isa_flag)
    else $error("base SUPPORTED_ISA_FIELD report wrong");
  a_boot_sample: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    $past(rst_n) |-> boot_isa_select_q == $past(config_word_zero[6]))
    else $error("boot SUPPORTED_ISA_FIELD bit not sampled");
endmodule : prefetch_cache_waitstate_cfg

// *** bench/core_fetch_model.sv ***
`timescale 1ns/1ps
module core_fetch_model (
  input  wire logic clk_sys,
  input  wire logic flash_rd_busy,
  input  wire logic flash_rd_ready,
  output logic      flash_rd_req
);
  initial flash_rd_req = 1'b0;
  task automatic fetch(output int lat);
    while (flash_rd_busy === 1'b1) @(posedge clk_sys);
    @(posedge clk_sys);
    flash_rd_req <= 1'b1;
    @(posedge clk_sys);
    flash_rd_req <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      #1;
      lat++;
    end while (flash_rd_ready !== 1'b1 && lat < 40);
  endtask : fetch
endmodule : core_fetch_model

// *** bench/tb_prefetch_cache_waitstate_cfg.sv ***
`timescale 1ns/1ps
`include "pfc_map.svh"
module tb_prefetch_cache_waitstate_cfg;
  logic        clk_sys, rst_n, reg_wr, reg_rd, flash_rd_req, flash_rd_busy, flash_rd_ready;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, config_word_zero, d;
  logic        pf_enable, pf_instr_en, pf_data_en, pf_any_en, exc_compressed_isa;
  logic        icache_en, dcache_en, cache_write_back, cache_write_alloc, mixed_opcode_en;
  int          error_cnt, n_tests, lat;
  logic [3:0]  pf_exp [4] = '{4'h0, 4'hc, 4'he, 4'hf};
  logic [3:0]  ca_exp [4] = '{4'hc, 4'hd, 4'h0, 4'hf};
  logic [2:0]  wcode [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  int          wexp [6] = '{0, 1, 2, 4, 4, 7};

  prefetch_cache_waitstate_cfg u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .config_word_zero(config_word_zero), .flash_rd_req(flash_rd_req),
    .flash_rd_busy(flash_rd_busy), .flash_rd_ready(flash_rd_ready), .pf_enable(pf_enable),
    .pf_instr_en(pf_instr_en), .pf_data_en(pf_data_en), .pf_any_en(pf_any_en),
    .icache_en(icache_en), .dcache_en(dcache_en), .cache_write_back(cache_write_back),
    .cache_write_alloc(cache_write_alloc), .exc_compressed_isa(exc_compressed_isa),
    .mixed_opcode_en(mixed_opcode_en));
  core_fetch_model u_core (.clk_sys(clk_sys), .flash_rd_busy(flash_rd_busy),
    .flash_rd_ready(flash_rd_ready), .flash_rd_req(flash_rd_req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    config_word_zero = 32'h0000_0040;
    error_cnt = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`ADDR_PREFETCH_CTRL, d); chk(d, 32'h0000_0007);
    rd(`ADDR_CACHE_ATTR, d); chk(d, 32'h0000_0002);
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, d); chk(d, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_PREFETCH_CTRL, {26'h0, s[1:0], 4'h0});
      repeat (2) @(posedge clk_sys);
      #1;
      chk({28'h0, pf_enable, pf_instr_en, pf_data_en, pf_any_en}, {28'h0, pf_exp[s]});
      rd(`ADDR_PREFETCH_CTRL, d); chk(d, {26'h0, s[1:0], 4'h0});
    end
    for (int i = 0; i < 6; i++) begin
      wr(`ADDR_PREFETCH_CTRL, {29'h0, wcode[i]});
      u_core.fetch(lat);
      chk(lat, 32'(1 + wexp[i]));
    end
    for (int c = 0; c < 4; c++) begin
      wr(`ADDR_CACHE_ATTR, 32'(c));
      repeat (2) @(posedge clk_sys);
      #1;
      chk({28'h0, icache_en, dcache_en, cache_write_back, cache_write_alloc}, {28'h0, ca_exp[c]});
    end
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_sys);
      config_word_zero <= {25'h0, b[0], 6'h0};
      repeat (3) @(posedge clk_sys);
      #1;
      chk({30'h0, exc_compressed_isa, mixed_opcode_en}, {30'h0, !b[0], !b[0]});
      rd(`ADDR_CORE_CFG3, d); chk({29'h0, d[16:14]}, b ? 32'h0000_0002 : 32'h0000_0007);
    end
    test_done();
  end
endmodule : tb_prefetch_cache_waitstate_cfg
